//--- logic/cag_pkg.sv
// ==========================================================
// Address generation constants and carriers
package cag_pkg;

    // ======================================================
    // Address map figures
    localparam logic [19:0] TABLE_BASE   = 20'h00080;
    localparam logic [19:0] TABLE_LAST   = 20'h000bf;
    localparam logic [3:0]  DIRECT_BANK  = 4'hf;
    localparam logic [3:0]  IMM16_BANK   = 4'h0;
    localparam logic [3:0]  TABLE_BANK   = 4'h0;
    localparam logic [19:0] SHORT_FIRST  = 20'hffe20;
    localparam logic [19:0] SHORT_LAST   = 20'hfff1f;
    localparam logic [7:0]  SHORT_SPLIT  = 8'h20;
    localparam logic [7:0]  SHORT_PAGE_LO = 8'hfe;
    localparam logic [7:0]  SHORT_PAGE_HI = 8'hff;
    localparam logic [3:0]  SHORT_BANK   = 4'hf;
    localparam logic [1:0]  PAIR_AX      = 2'h0;
    localparam logic [2:0]  REG_X        = 3'h0;
    localparam logic [2:0]  REG_A        = 3'h1;

    // ======================================================
    // Reset values
    localparam logic [19:0] ADDR_RST     = 20'h00000;

    // ======================================================
    // Operation requested by the decoder
    typedef enum logic [3:0] {
        OP_BR_REL      = 4'h0,
        OP_CALL_IMM20  = 4'h1,
        OP_BR_IMM20    = 4'h2,
        OP_CALL_IMM16  = 4'h3,
        OP_BR_IMM16    = 4'h4,
        OP_TABLE_CALL  = 4'h5,
        OP_CALL_REG    = 4'h6,
        OP_BR_REG      = 4'h7,
        OP_IMPLIED     = 4'h8,
        OP_REG8        = 4'h9,
        OP_REG16       = 4'ha,
        OP_DIRECT      = 4'hb,
        OP_ES_DIRECT   = 4'hc,
        OP_SHORT_BYTE  = 4'hd,
        OP_SHORT_WORD  = 4'he,
        OP_NONE        = 4'hf
    } cag_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RD_LO = 2'h1,
        ST_RD_HI = 2'h2
    } cag_state_e;

    // Decoder request
    typedef struct packed {
        cag_op_e     op;
        logic        branch_class; // Instruction is a branch
        logic        disp_wide;    // 16-bit displacement
        logic [15:0] disp;
        logic [19:0] imm;          // Immediate address field
        logic [2:0]  reg_field;
        logic [1:0]  pair_field;
        logic [19:0] next_pc;
    } cag_req_s;

    // Program counter load
    typedef struct packed {
        logic [19:0] target;
        logic        is_call;
    } cag_pc_s;

    // Data operand
    typedef struct packed {
        logic [19:0] addr;
        logic        is_reg;
        logic        is_word;
        logic [2:0]  reg_idx;
        logic [2:0]  reg_idx2;
        logic [15:0] value;
    } cag_data_s;

endpackage

//--- logic/cag_reg_select.sv
`timescale 1ns/1ns
// ==========================================================
// Register field decoder for the active bank
module cag_reg_select
(
    // Active bank contents, index 0..7 = X A C B E D L H
    input  wire logic [7:0][7:0] bank,
    // Fields
    input  wire logic [2:0]      reg_field,
    input  wire logic [1:0]      pair_field,
    // Selected values
    output logic      [7:0]      reg_value,
    output logic      [15:0]     pair_value
);

    // One of eight bytes, one of four pairs
    always_comb
    begin
        reg_value  = bank[reg_field];
        pair_value = {bank[{pair_field, 1'b1}], bank[{pair_field, 1'b0}]};
    end

endmodule

//--- logic/cag_short_map.sv
`timescale 1ns/1ns
// ==========================================================
// Short direct field to physical address
module cag_short_map
(
    // Operand field
    input  wire logic [7:0]  field,
    input  wire logic        word,
    // Physical result
    output logic      [19:0] addr,
    output logic             misaligned
);

    // Bytes 20..ff fall on page fe, 00..1f on page ff
    always_comb
    begin
        if (field >= cag_pkg::SHORT_SPLIT)
            addr = {cag_pkg::SHORT_BANK, cag_pkg::SHORT_PAGE_LO, field};
        else
            addr = {cag_pkg::SHORT_BANK, cag_pkg::SHORT_PAGE_HI, field};
        misaligned = word & field[0];
    end

endmodule

//--- logic/cag_addr_gen.sv
`timescale 1ns/1ns
// Notes on behaviour
// - relative branch loads next pc plus signed 8- or 16-bit displacement
// - relative target only for branch class, otherwise refused
// - long immediate call and branch load the full 20-bit field
// - short immediate call and branch force upper four pc bits to zero
// - table call reads two bytes at 0080H plus twice 5-bit index
// - table mode only for table call; targets stay in 00000H-0FFFFH
// - register branch uses code bank and pair; only call reg and branch AX
// - implied operand selection only for unsigned multiply with low byte
// - 3-bit field picks byte register, 2-bit field picks pair
// - plain direct places 16-bit address in F0000H-FFFFFH
// - segment direct takes upper four bits from extended segment register
// - short direct 8-bit field reaches only FFE20H-FFF1FH
// - short direct word access uses even address only
// - short operands written 0FE20H-0FF1FH land on FFE20H-FFF1FH
module cag_addr_gen
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Decoder request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire cag_pkg::cag_req_s req,
    // Register file view
    input  wire logic [7:0][7:0]   bank,
    input  wire logic [3:0]        code_bank,
    input  wire logic [3:0]        extended_segment_reg,
    // Table memory read
    output logic                   mem_req_valid,
    input  wire logic              mem_req_ready,
    output logic [19:0]            mem_addr,
    input  wire logic              mem_rdata_valid,
    input  wire logic [7:0]        mem_rdata,
    // Program counter load
    output logic                   pc_load,
    output cag_pkg::cag_pc_s       pc_out,
    // Data operand
    output logic                   data_valid,
    output cag_pkg::cag_data_s     data_out,
    // Refused request
    output logic                   illegal
);

    // ======================================================
    // Declarations
    cag_pkg::cag_state_e state_r;
    cag_pkg::cag_state_e state_nxt;
    logic                issued_r;
    logic [7:0]          tbl_lo_r;
    logic [19:0]         tbl_addr_r;
    logic                pc_load_r;
    cag_pkg::cag_pc_s    pc_r;
    logic                data_valid_r;
    cag_pkg::cag_data_s  data_r;
    logic                illegal_r;
    logic [7:0]          reg_value;
    logic [15:0]         pair_value;
    logic [19:0]         short_addr;
    logic                short_mis;
    logic                take;
    logic [19:0]         rel_target;
    logic [19:0]         disp_ext;
    logic                is_branch_op;
    logic                refuse;

    // ======================================================
    // Helpers
    cag_reg_select u_regsel
    (
        .bank       (bank),
        .reg_field  (req.reg_field),
        .pair_field (req.pair_field),
        .reg_value  (reg_value),
        .pair_value (pair_value)
    );

    // Only the low byte of the short operand reaches the mapper
    cag_short_map u_short
    (
        .field      (req.imm[7:0]),
        .word       (req.op == cag_pkg::OP_SHORT_WORD),
        .addr       (short_addr),
        .misaligned (short_mis)
    );

    // ======================================================
    // Request handshake
    assign req_ready = (state_r == cag_pkg::ST_IDLE);
    assign take      = req_valid & req_ready;

    // Sign extend the displacement
    always_comb
    begin
        if (req.disp_wide)
            disp_ext = {{4{req.disp[15]}}, req.disp};
        else
            disp_ext = {{12{req.disp[7]}}, req.disp[7:0]};
        rel_target = req.next_pc + disp_ext;
    end

    // Branch ops are the first eight codes
    assign is_branch_op = (req.op <= cag_pkg::OP_BR_REG);

    // Forms refused at take time
    always_comb
    begin
        refuse = 1'b0;
        case (req.op)
            cag_pkg::OP_BR_REL:
                refuse = ~req.branch_class;
            cag_pkg::OP_BR_REG:
                refuse = (req.pair_field != cag_pkg::PAIR_AX);
            cag_pkg::OP_SHORT_WORD:
                refuse = short_mis;
            cag_pkg::OP_NONE:
                refuse = 1'b1;
            default:
                refuse = 1'b0;
        endcase
    end

    // ======================================================
    // Table call sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            cag_pkg::ST_IDLE:
            begin
                if (take && req.op == cag_pkg::OP_TABLE_CALL)
                    state_nxt = cag_pkg::ST_RD_LO;
            end
            cag_pkg::ST_RD_LO:
            begin
                if (mem_rdata_valid && issued_r)
                    state_nxt = cag_pkg::ST_RD_HI;
            end
            cag_pkg::ST_RD_HI:
            begin
                if (mem_rdata_valid && issued_r)
                    state_nxt = cag_pkg::ST_IDLE;
            end
            default:
                state_nxt = cag_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= cag_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Read issue flag: one request per byte
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            issued_r <= 1'b0;
        else if (mem_rdata_valid && issued_r)
            issued_r <= 1'b0;
        else if (mem_req_valid && mem_req_ready)
            issued_r <= 1'b1;
    end

    // Table entry address, low byte first, then steps to the high byte
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tbl_addr_r <= cag_pkg::ADDR_RST;
        else if (take && req.op == cag_pkg::OP_TABLE_CALL)
            tbl_addr_r <= cag_pkg::TABLE_BASE + {14'h0000, req.imm[4:0], 1'b0};
        else if (state_r == cag_pkg::ST_RD_LO && mem_rdata_valid && issued_r)
            tbl_addr_r <= tbl_addr_r + 20'h00001;
    end

    // Low byte of the entry
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tbl_lo_r <= 8'h00;
        else if (state_r == cag_pkg::ST_RD_LO && mem_rdata_valid && issued_r)
            tbl_lo_r <= mem_rdata;
    end

    // Memory read port
    assign mem_req_valid = (state_r != cag_pkg::ST_IDLE) & ~issued_r;
    assign mem_addr      = tbl_addr_r;

    // ======================================================
    // Program counter result
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pc_load_r <= 1'b0;
        else if (state_r == cag_pkg::ST_RD_HI && mem_rdata_valid && issued_r)
            pc_load_r <= 1'b1;
        else
            pc_load_r <= take & is_branch_op & ~refuse
                         & (req.op != cag_pkg::OP_TABLE_CALL);
    end

    // Target selection per branch form
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pc_r <= '0;
        end
        else if (state_r == cag_pkg::ST_RD_HI && mem_rdata_valid && issued_r)
        begin
            pc_r.target  <= {cag_pkg::TABLE_BANK, mem_rdata, tbl_lo_r};
            pc_r.is_call <= 1'b1;
        end
        else if (take && is_branch_op)
        begin
            pc_r.is_call <= (req.op == cag_pkg::OP_CALL_IMM20)
                          | (req.op == cag_pkg::OP_CALL_IMM16)
                          | (req.op == cag_pkg::OP_CALL_REG);
            case (req.op)
                cag_pkg::OP_BR_REL:
                    pc_r.target <= rel_target;
                cag_pkg::OP_CALL_IMM20,
                cag_pkg::OP_BR_IMM20:
                    pc_r.target <= req.imm;
                cag_pkg::OP_CALL_IMM16,
                cag_pkg::OP_BR_IMM16:
                    pc_r.target <= {cag_pkg::IMM16_BANK, req.imm[15:0]};
                cag_pkg::OP_CALL_REG,
                cag_pkg::OP_BR_REG:
                    pc_r.target <= {code_bank, pair_value};
                default:
                    pc_r.target <= pc_r.target;
            endcase
        end
    end

    // ======================================================
    // Data operand result
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            data_valid_r <= 1'b0;
        else
            data_valid_r <= take & ~is_branch_op & ~refuse;
    end

    // Address or register selection per data form
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_r <= '0;
        end
        else if (take && !is_branch_op)
        begin
            data_r.is_reg   <= 1'b0;
            data_r.is_word  <= 1'b0;
            data_r.reg_idx  <= req.reg_field;
            data_r.reg_idx2 <= req.reg_field;
            data_r.value    <= 16'h0000;
            data_r.addr     <= data_r.addr;
            case (req.op)
                cag_pkg::OP_IMPLIED:
                begin
                    data_r.is_reg   <= 1'b1;
                    data_r.reg_idx  <= cag_pkg::REG_A;
                    data_r.reg_idx2 <= cag_pkg::REG_X;
                    data_r.value    <= {bank[cag_pkg::REG_A], bank[cag_pkg::REG_X]};
                end
                cag_pkg::OP_REG8:
                begin
                    data_r.is_reg <= 1'b1;
                    data_r.value  <= {8'h00, reg_value};
                end
                cag_pkg::OP_REG16:
                begin
                    data_r.is_reg   <= 1'b1;
                    data_r.is_word  <= 1'b1;
                    data_r.reg_idx  <= {req.pair_field, 1'b1};
                    data_r.reg_idx2 <= {req.pair_field, 1'b0};
                    data_r.value    <= pair_value;
                end
                cag_pkg::OP_DIRECT:
                    data_r.addr <= {cag_pkg::DIRECT_BANK, req.imm[15:0]};
                cag_pkg::OP_ES_DIRECT:
                    data_r.addr <= {extended_segment_reg, req.imm[15:0]};
                cag_pkg::OP_SHORT_BYTE:
                    data_r.addr <= short_addr;
                cag_pkg::OP_SHORT_WORD:
                begin
                    data_r.addr    <= short_addr;
                    data_r.is_word <= 1'b1;
                end
                default:
                    data_r.addr <= data_r.addr;
            endcase
        end
    end

    // ======================================================
    // Refusal pulse
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            illegal_r <= 1'b0;
        else
            illegal_r <= take & refuse;
    end

    // Outputs
    assign pc_load    = pc_load_r;
    assign pc_out     = pc_r;
    assign data_valid = data_valid_r;
    assign data_out   = data_r;
    assign illegal    = illegal_r;

endmodule

//--- tb/cag_addr_gen_asserts.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks for the address generator
module cag_addr_gen_asserts
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Request side
    input  wire logic               req_valid,
    input  wire logic               req_ready,
    input  wire cag_pkg::cag_req_s  req,
    input  wire logic [7:0][7:0]    bank,
    input  wire logic [3:0]         code_bank,
    input  wire logic [3:0]         extended_segment_reg,
    // Table memory
    input  wire logic               mem_req_valid,
    input  wire logic               mem_req_ready,
    input  wire logic [19:0]        mem_addr,
    input  wire logic               mem_rdata_valid,
    input  wire logic [7:0]         mem_rdata,
    // Results
    input  wire logic               pc_load,
    input  wire cag_pkg::cag_pc_s   pc_out,
    input  wire logic               data_valid,
    input  wire cag_pkg::cag_data_s data_out,
    input  wire logic               illegal
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Taken request and the figures it implies
    logic        tk;
    logic [3:0]  op;
    logic [19:0] rel;
    logic [19:0] tbl;
    logic [15:0] pv;
    logic        tc_r;
    assign tk  = req_valid && req_ready;
    assign op  = req.op;
    assign rel = req.next_pc + (req.disp_wide ? {{4{req.disp[15]}}, req.disp}
                                              : {{12{req.disp[7]}}, req.disp[7:0]});
    assign tbl = cag_pkg::TABLE_BASE + {14'h0, req.imm[4:0], 1'b0};
    assign pv  = {bank[{req.pair_field, 1'b1}], bank[{req.pair_field, 1'b0}]};

    // Marks a table call in flight until its target loads
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tc_r <= 1'b0;
        else if (tk && op == cag_pkg::OP_TABLE_CALL)
            tc_r <= 1'b1;
        else if (pc_load)
            tc_r <= 1'b0;
    end

    // ======================================================
    // Branch targets
    a_rel_target: assert property (tk && op == cag_pkg::OP_BR_REL && req.branch_class
        |=> pc_load && pc_out.target == $past(rel)) else $error("relative target wrong");
    a_rel_refuse: assert property (tk && op == cag_pkg::OP_BR_REL && !req.branch_class
        |=> illegal && !pc_load) else $error("relative without branch accepted");
    a_imm20_load: assert property (tk && op inside {4'h1, 4'h2}
        |=> pc_load && pc_out.target == $past(req.imm)) else $error("imm20 target wrong");
    a_imm16_zero: assert property (tk && op inside {4'h3, 4'h4}
        |=> pc_load && pc_out.target == {4'h0, $past(req.imm[15:0])})
        else $error("imm16 target wrong");
    a_table_first: assert property (tk && op == cag_pkg::OP_TABLE_CALL
        |=> mem_req_valid && mem_addr == $past(tbl)) else $error("table entry address wrong");
    a_table_span: assert property (mem_req_valid
        |-> mem_addr >= cag_pkg::TABLE_BASE && mem_addr <= cag_pkg::TABLE_LAST)
        else $error("table read outside table");
    a_table_bank: assert property (pc_load && tc_r
        |-> pc_out.target[19:16] == 4'h0 && pc_out.is_call) else $error("table target bank");
    a_reg_target: assert property (tk && (op == cag_pkg::OP_CALL_REG
        || op == cag_pkg::OP_BR_REG && req.pair_field == 2'h0)
        |=> pc_load && pc_out.target == {$past(code_bank), $past(pv)})
        else $error("register target wrong");

    // ======================================================
    // Data operands
    a_implied_sel: assert property (tk && op == cag_pkg::OP_IMPLIED |=> data_valid
        && data_out.reg_idx == cag_pkg::REG_A && data_out.reg_idx2 == cag_pkg::REG_X)
        else $error("implied registers wrong");
    a_reg_field: assert property (tk && op == cag_pkg::OP_REG8
        |=> data_valid && data_out.reg_idx == $past(req.reg_field)) else $error("reg field");
    a_direct_top: assert property (tk && op == cag_pkg::OP_DIRECT
        |=> data_valid && data_out.addr == {4'hf, $past(req.imm[15:0])})
        else $error("direct address wrong");
    a_es_upper: assert property (tk && op == cag_pkg::OP_ES_DIRECT
        |=> data_out.addr == {$past(extended_segment_reg), $past(req.imm[15:0])})
        else $error("segment address wrong");
    a_short_span: assert property (tk && op == cag_pkg::OP_SHORT_BYTE
        |=> data_valid && data_out.addr >= cag_pkg::SHORT_FIRST
        && data_out.addr <= cag_pkg::SHORT_LAST && data_out.addr[7:0] == $past(req.imm[7:0]))
        else $error("short address wrong");
    a_short_odd: assert property (tk && op == cag_pkg::OP_SHORT_WORD && req.imm[0]
        |=> illegal && !data_valid) else $error("odd word accepted");

    // Main scenarios reached
    c_table: cover property (pc_load && tc_r);
    c_short: cover property (tk && op == cag_pkg::OP_SHORT_WORD);
    c_refuse: cover property (illegal);
endmodule

bind cag_addr_gen cag_addr_gen_asserts chk_u (.clk, .resetn, .req_valid, .req_ready, .req,
    .bank, .code_bank, .extended_segment_reg, .mem_req_valid, .mem_req_ready, .mem_addr,
    .mem_rdata_valid, .mem_rdata, .pc_load, .pc_out, .data_valid, .data_out, .illegal);

//--- tb/cpu_address_generation_test.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the address generator
module cpu_address_generation_test;
    logic               clk;
    logic               resetn;
    logic               req_valid;
    logic               req_ready;
    cag_pkg::cag_req_s  req;
    logic [7:0][7:0]    bank;
    logic [3:0]         code_bank;
    logic [3:0]         extended_segment_reg;
    logic               mem_req_valid;
    logic               mem_req_ready;
    logic [19:0]        mem_addr;
    logic               mem_rdata_valid;
    logic [7:0]         mem_rdata;
    logic               pc_load;
    cag_pkg::cag_pc_s   pc_out;
    logic               data_valid;
    cag_pkg::cag_data_s data_out;
    logic               illegal;
    logic [7:0]         mem [0:255];
    logic [44:0]        note_q [$];
    logic [44:0]        e_n;
    logic [19:0]        v_n;
    logic [31:0]        st;
    logic [31:0]        t;
    logic [95:0]        b;
    logic [7:0]         rd_addr;
    logic               rd_pend;
    int                 bad_count;
    int                 num_checks;
    int                 cycles;

    cag_addr_gen dut_u (.clk, .resetn, .req_valid, .req_ready, .req, .bank, .code_bank,
        .extended_segment_reg, .mem_req_valid, .mem_req_ready, .mem_addr, .mem_rdata_valid,
        .mem_rdata, .pc_load, .pc_out, .data_valid, .data_out, .illegal);

    // Clock
    always #10 clk = ~clk;

    // Xorshift source
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    // Comparison and report
    task automatic chk(input string name, input logic [44:0] seen, input logic [44:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Expected result: {illegal,data,pc, source, value, mask}
    function automatic logic [44:0] model(input cag_pkg::cag_req_s r);
        logic [15:0] pv;
        logic [19:0] sd;
        logic [7:0]  lo;
        logic [19:0] sh;
        pv = {bank[{r.pair_field, 1'b1}], bank[{r.pair_field, 1'b0}]};
        sd = r.disp_wide ? {{4{r.disp[15]}}, r.disp} : {{12{r.disp[7]}}, r.disp[7:0]};
        lo = 8'h80 + {2'h0, r.imm[4:0], 1'b0};
        sh = {(r.imm[7:0] >= 8'h20) ? 12'hffe : 12'hfff, r.imm[7:0]};
        model = {5'b10000, 40'h0};
        case (r.op)
            4'h0: if (r.branch_class) model = {5'h04, r.next_pc + sd, 20'hfffff};
            4'h1, 4'h2: model = {5'h04, r.imm, 20'hfffff};
            4'h3, 4'h4: model = {5'h04, 4'h0, r.imm[15:0], 20'hfffff};
            4'h5: model = {5'h04, 4'h0, mem[lo + 8'h01], mem[lo], 20'hfffff};
            4'h6: model = {5'h04, code_bank, pv, 20'hfffff};
            4'h7: if (r.pair_field == 2'h0) model = {5'h04, code_bank, pv, 20'hfffff};
            4'h8: model = {5'h0a, 6'h08, bank[1][5:0], bank[0], 20'hfffff};
            4'h9: model = {5'h0a, r.reg_field, r.reg_field, 6'h00, bank[r.reg_field], 20'hfffff};
            4'ha: model = {5'h0a, r.pair_field, 1'b1, r.pair_field, 1'b0, pv[13:0], 20'hfffff};
            4'hb: model = {5'h09, 4'hf, r.imm[15:0], 20'hfffff};
            4'hc: model = {5'h09, extended_segment_reg, r.imm[15:0], 20'hfffff};
            4'hd: model = {5'h09, sh, 20'hfffff};
            4'he: if (!r.imm[0]) model = {5'h09, sh, 20'hfffff};
            default: model = {5'b10000, 40'h0};
        endcase
    endfunction

    // Present one request at a falling edge and hold it until taken
    task automatic send(input cag_pkg::cag_req_s r);
        bank = {rnd(), rnd()};
        {code_bank, extended_segment_reg} = 8'(rnd());
        req = r;
        req_valid = 1'b1;
        note_q.push_back(model(r));
        while (!req_ready)
            @(negedge clk);
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic go(input cag_pkg::cag_op_e op, input logic [19:0] imm, input logic [17:0] x);
        cag_pkg::cag_req_s r;
        b = {rnd(), rnd(), rnd()};
        r = b[66:0];
        r.op = op;
        r.imm = imm;
        {r.branch_class, r.disp_wide, r.disp} = x;
        send(r);
    endtask

    // Table memory: random stalls and read latency
    always @(posedge clk)
        if (mem_req_valid && mem_req_ready)
        begin
            rd_addr = mem_addr[7:0];
            rd_pend = 1'b1;
        end

    always @(negedge clk)
    begin
        t = rnd();
        mem_req_ready = t[0] | t[1];
        mem_rdata = t[15:8];
        mem_rdata_valid = 1'b0;
        if (rd_pend && t[2])
        begin
            mem_rdata_valid = 1'b1;
            mem_rdata = mem[rd_addr];
            rd_pend = 1'b0;
        end
    end

    // Result watcher takes the oldest note
    always @(negedge clk)
        if (resetn && (pc_load !== 1'b0 || data_valid !== 1'b0 || illegal !== 1'b0))
        begin
            e_n = (note_q.size() != 0) ? note_q.pop_front() : 45'h0;
            case (e_n[41:40])
                2'h0: v_n = pc_out.target;
                2'h1: v_n = data_out.addr;
                default: v_n = {data_out.reg_idx, data_out.reg_idx2, data_out.value[13:0]};
            endcase
            chk("result", {illegal, data_valid, pc_load, e_n[41:40], v_n & e_n[19:0], e_n[19:0]},
                {e_n[44:40], e_n[39:20] & e_n[19:0], e_n[19:0]});
        end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        st = 32'd18893;
        {clk, resetn, req_valid, rd_pend, mem_req_ready, mem_rdata_valid} = 6'h0;
        {req, bank, code_bank, extended_segment_reg, mem_rdata, rd_addr} = '0;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(rnd());
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        go(cag_pkg::OP_BR_REL, 20'h0, 18'h20080);
        go(cag_pkg::OP_BR_REL, 20'h0, 18'h2007f);
        go(cag_pkg::OP_BR_REL, 20'h0, 18'h37fff);
        go(cag_pkg::OP_BR_REL, 20'h0, 18'h38000);
        go(cag_pkg::OP_BR_REL, 20'h0, 18'h00010);
        go(cag_pkg::OP_BR_IMM16, 20'habcde, 18'h20000);
        go(cag_pkg::OP_TABLE_CALL, 20'h0, 18'h20000);
        go(cag_pkg::OP_TABLE_CALL, 20'h1f, 18'h20000);
        go(cag_pkg::OP_SHORT_BYTE, 20'h0fe20, 18'h0);
        go(cag_pkg::OP_SHORT_BYTE, 20'h0ff1f, 18'h0);
        go(cag_pkg::OP_SHORT_WORD, 20'hffe20, 18'h0);
        go(cag_pkg::OP_SHORT_WORD, 20'h00021, 18'h0);
        go(cag_pkg::OP_DIRECT, 20'h0ffff, 18'h0);
        // Every operation code once, then random traffic
        for (int i = 0; i < 16; i++)
            go(cag_pkg::cag_op_e'(i[3:0]), 20'h5a5a5, 18'h20000);
        for (int i = 0; i < 500; i++)
        begin
            b = {rnd(), rnd(), rnd()};
            send(b[66:0]);
        end
        req_valid = 1'b0;
        // A last table call may still wait on slow memory
        for (int i = 0; i < 200 && note_q.size() != 0; i++)
            @(negedge clk);
        repeat (2) @(negedge clk);
        chk("pending notes", 45'(note_q.size()), 45'h0);
        print_verdict();
    end
endmodule
